/* File: hw/dcf_pkg.sv */
// Constants for the FIFO pointer and flag block.
// Assumes one 50 MHz clock and a memory of 512 words of 9 bits.
package dcf_pkg;

	////////////////////////////////////////////////////////////////////
	// Pointer geometry
	localparam int unsigned PTR_W     = 12;
	localparam int unsigned IDX_W     = 9;
	localparam int unsigned THR_W     = 12;
	localparam logic [11:0] PTR_MAX   = 12'h1FF;
	localparam logic [11:0] PTR_RST   = 12'h000;
	localparam int unsigned WORD_BITS = 9;
	localparam int unsigned FILL_W    = 10;
	localparam int unsigned BITS_W    = 14;
	localparam int unsigned SYNC_STAGES = 2;

	////////////////////////////////////////////////////////////////////
	// Register port
	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned DATA_W    = 32;
	localparam logic [7:0]  REG_STATUS  = 8'h00;
	localparam logic [7:0]  REG_IRQ_EN  = 8'h04;
	localparam logic [7:0]  REG_IRQ_CLR = 8'h08;
	localparam logic [7:0]  REG_LEVEL   = 8'h0C;
	localparam logic [7:0]  REG_PTRS    = 8'h10;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////
	// Event bits of the status, enable and clear registers
	localparam int unsigned EV_W          = 6;
	localparam int unsigned EV_FULL       = 0;
	localparam int unsigned EV_EMPTY      = 1;
	localparam int unsigned EV_NEAR_FULL  = 2;
	localparam int unsigned EV_NEAR_EMPTY = 3;
	localparam int unsigned EV_OVERFLOW   = 4;
	localparam int unsigned EV_UNDERFLOW  = 5;
	localparam logic [5:0]  EV_RST        = 6'h00;
	localparam logic [5:0]  IRQ_EN_RST    = 6'h00;
	// Flag history at reset: empty and near-empty up, so no false edge
	localparam logic [5:0]  FLAGS_Q_RST   = 6'h0A;

	// Bit positions in the pointer readback word
	localparam int unsigned PTRS_WR_LSB = 0;
	localparam int unsigned PTRS_RD_LSB = 16;

endpackage : dcf_pkg

/* File: hw/dcf_flag_fifo.sv */
// FIFO pointer, full/empty and threshold flag logic for a 512x9 memory.
// Assumes writer, reader and register master all run on clk; memory
// itself sits outside and is addressed by the two pointers.
//
// The implementer's own choices: the register offsets and the strobed register port.

////////////////////////////////////////////////////////////////////////
// Operation
// - Read-halt high stops read counter once empty is raised.
// - Write-halt high stops write counter once full is raised.
// - Full flag lives on write side and blocks writes immediately.
// - Full compares write pointer with delayed copy of read pointer.
// - Full stays set two write edges after a freeing read.
// - Empty flag lives on read side and blocks reads immediately.
// - Empty compares read pointer with delayed copy of write pointer.
// - Empty stays set two read edges after a filling write.
// - Near-empty and near-full thresholds are 12-bit inputs from user.
// - Separate 12-bit write and read counters, each steps by one.
// - Counters start at zero, reach 511, then wrap to zero.
// - Near-full set when pointer difference reaches threshold.
// - Near-empty set when pointer difference is at most threshold.
// - Thresholds count data bits, not words.
// - Near-full holds until difference falls below threshold.
// - Read-halt low lets read counter wrap past empty to reread.
module dcf_flag_fifo (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Write side
	input  wire logic        wr_req,
	input  wire logic        write_counter_halt,
	output logic             write_accept,
	output logic [11:0]      write_pointer,
	// Read side
	input  wire logic        rd_req,
	input  wire logic        read_counter_halt,
	output logic             read_accept,
	output logic [11:0]      read_pointer,
	// Flags and thresholds
	input  wire logic [11:0] near_full_threshold,
	input  wire logic [11:0] near_empty_threshold,
	output logic             full_flag,
	output logic             empty_flag,
	output logic             near_full_flag,
	output logic             near_empty_flag,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Interrupt
	output logic             irq
);

	////////////////////////////////////////////////////////////////////
	// Pointers: 12-bit counter plus a lap bit to tell full from empty
	logic [11:0] wp_ff;
	logic [11:0] rp_ff;
	logic        wlap_ff;
	logic        rlap_ff;
	logic        wr_adv;
	logic        rd_adv;

	// Delayed copies crossing into the opposite side
	logic [12:0] rp_s1_ff;
	logic [12:0] rp_s2_ff;
	logic [12:0] wp_s1_ff;
	logic [12:0] wp_s2_ff;

	logic [9:0]  wfill;
	logic [9:0]  rfill;
	logic [13:0] wfill_bits;
	logic [13:0] rfill_bits;

	assign write_pointer = wp_ff;
	assign read_pointer  = rp_ff;

	// A halted counter freezes only while its flag is up
	assign wr_adv = wr_req && !(full_flag && write_counter_halt);
	assign rd_adv = rd_req && !(empty_flag && read_counter_halt);

	// Memory is touched only when the flag allows it
	assign write_accept = wr_req && !full_flag;
	assign read_accept  = rd_req && !empty_flag;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			wp_ff   <= dcf_pkg::PTR_RST;
			wlap_ff <= 1'b0;
		end else if (wr_adv) begin
			if (wp_ff == dcf_pkg::PTR_MAX) begin
				wp_ff   <= dcf_pkg::PTR_RST;
				wlap_ff <= !wlap_ff;
			end else begin
				wp_ff <= wp_ff + 12'h001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rp_ff   <= dcf_pkg::PTR_RST;
			rlap_ff <= 1'b0;
		end else if (rd_adv) begin
			if (rp_ff == dcf_pkg::PTR_MAX) begin
				rp_ff   <= dcf_pkg::PTR_RST;
				rlap_ff <= !rlap_ff;
			end else begin
				rp_ff <= rp_ff + 12'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Two-stage copies; the flag that drops waits out both stages
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rp_s1_ff <= 13'h0000;
			rp_s2_ff <= 13'h0000;
			wp_s1_ff <= 13'h0000;
			wp_s2_ff <= 13'h0000;
		end else begin
			rp_s1_ff <= {rlap_ff, rp_ff};
			rp_s2_ff <= rp_s1_ff;
			wp_s1_ff <= {wlap_ff, wp_ff};
			wp_s2_ff <= wp_s1_ff;
		end
	end

	// Raised at once by own side, released late by the far side
	assign full_flag = (wp_ff[8:0] == rp_s2_ff[8:0]) &&
		(wlap_ff != rp_s2_ff[12]);
	assign empty_flag = (rp_ff[8:0] == wp_s2_ff[8:0]) &&
		(rlap_ff == wp_s2_ff[12]);

	// Words held, seen from each side; lap bit makes 512 reachable
	assign wfill = {1'b0, wp_ff[8:0]} - {1'b0, rp_s2_ff[8:0]} +
		((wlap_ff != rp_s2_ff[12]) ? 10'h200 : 10'h000);
	assign rfill = {1'b0, wp_s2_ff[8:0]} - {1'b0, rp_ff[8:0]} +
		((rlap_ff != wp_s2_ff[12]) ? 10'h200 : 10'h000);

	// Scaled to data bits so mixed port widths share one threshold
	assign wfill_bits = 14'(wfill * 10'(dcf_pkg::WORD_BITS));
	assign rfill_bits = 14'(rfill * 10'(dcf_pkg::WORD_BITS));

	// Zero fill never counts as near full, so reset leaves it low
	assign near_full_flag = (wfill != 10'h000) &&
		(wfill_bits >= {2'b00, near_full_threshold});
	assign near_empty_flag =
		(rfill_bits <= {2'b00, near_empty_threshold});

	////////////////////////////////////////////////////////////////////
	// Event detection
	logic [5:0] flags_q_ff;
	logic [5:0] events;
	logic [5:0] status_ff;
	logic [5:0] irq_en_ff;
	logic [5:0] clr_mask;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			flags_q_ff <= dcf_pkg::FLAGS_Q_RST;
		end else begin
			flags_q_ff <= {2'b00, near_empty_flag, near_full_flag,
				empty_flag, full_flag};
		end
	end

	always_comb begin
		events = 6'h00;
		events[dcf_pkg::EV_FULL] = full_flag &&
			!flags_q_ff[dcf_pkg::EV_FULL];
		events[dcf_pkg::EV_EMPTY] = empty_flag &&
			!flags_q_ff[dcf_pkg::EV_EMPTY];
		events[dcf_pkg::EV_NEAR_FULL] = near_full_flag &&
			!flags_q_ff[dcf_pkg::EV_NEAR_FULL];
		events[dcf_pkg::EV_NEAR_EMPTY] = near_empty_flag &&
			!flags_q_ff[dcf_pkg::EV_NEAR_EMPTY];
		events[dcf_pkg::EV_OVERFLOW]  = wr_req && full_flag;
		events[dcf_pkg::EV_UNDERFLOW] = rd_req && empty_flag;
	end

	////////////////////////////////////////////////////////////////////
	// Register port
	always_comb begin
		clr_mask = 6'h00;
		if (reg_wr && reg_addr == dcf_pkg::REG_IRQ_CLR) begin
			clr_mask = reg_wdata[5:0];
		end
	end

	// A new event in the clearing cycle survives the clear
	always_ff @(posedge clk) begin
		if (!nrst) begin
			status_ff <= dcf_pkg::EV_RST;
		end else begin
			status_ff <= (status_ff & ~clr_mask) | events;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq_en_ff <= dcf_pkg::IRQ_EN_RST;
		end else if (reg_wr && reg_addr == dcf_pkg::REG_IRQ_EN) begin
			irq_en_ff <= reg_wdata[5:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			reg_rdata <= dcf_pkg::RD_UNMAPPED;
		end else if (reg_rd) begin
			if (reg_addr == dcf_pkg::REG_STATUS) begin
				reg_rdata <= {26'h0, status_ff};
			end else if (reg_addr == dcf_pkg::REG_IRQ_EN) begin
				reg_rdata <= {26'h0, irq_en_ff};
			end else if (reg_addr == dcf_pkg::REG_LEVEL) begin
				reg_rdata <= {22'h0, wfill};
			end else if (reg_addr == dcf_pkg::REG_PTRS) begin
				reg_rdata <= {3'h0, rlap_ff, rp_ff, 3'h0, wlap_ff, wp_ff};
			end else begin
				reg_rdata <= dcf_pkg::RD_UNMAPPED;
			end
		end else begin
			reg_rdata <= dcf_pkg::RD_UNMAPPED;
		end
	end

	assign irq = |(status_ff & irq_en_ff);

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_wr_block;
		full_flag && wr_req |-> !write_accept;
	endproperty
	a_wr_block: assert property (p_wr_block)
		else $error("write accepted while full");

	property p_rd_block;
		empty_flag && rd_req |-> !read_accept;
	endproperty
	a_rd_block: assert property (p_rd_block)
		else $error("read accepted while empty");

	// Own-side step past the flag (halt low) ends it at once
	property p_full_release;
		$fell(full_flag) && !$past(wr_adv)
			|-> $past(rd_adv, 3);
	endproperty
	a_full_release: assert property (p_full_release)
		else $error("full dropped without read three cycles back");

	// Reread past empty ends the flag without any write
	property p_empty_release;
		$fell(empty_flag) && !$past(rd_adv)
			|-> $past(wr_adv, 3);
	endproperty
	a_empty_release: assert property (p_empty_release)
		else $error("empty dropped without write three cycles back");

	property p_full_stays;
		full_flag && rd_adv && !wr_adv |=> full_flag ##1 full_flag;
	endproperty
	a_full_stays: assert property (p_full_stays)
		else $error("full released before two edges");

	property p_empty_stays;
		empty_flag && wr_adv && !rd_adv |=> empty_flag ##1 empty_flag;
	endproperty
	a_empty_stays: assert property (p_empty_stays)
		else $error("empty released before two edges");

	property p_wr_halt;
		full_flag && write_counter_halt |=> $stable(write_pointer);
	endproperty
	a_wr_halt: assert property (p_wr_halt)
		else $error("write counter moved while halted at full");

	property p_rd_halt;
		empty_flag && read_counter_halt |=> $stable(read_pointer);
	endproperty
	a_rd_halt: assert property (p_rd_halt)
		else $error("read counter moved while halted at empty");

	property p_rd_reread;
		rd_req && !read_counter_halt && read_pointer != 12'h1FF
			|=> read_pointer == $past(read_pointer) + 12'h001;
	endproperty
	a_rd_reread: assert property (p_rd_reread)
		else $error("read counter did not advance when not halted");

	property p_wr_step;
		wr_adv && write_pointer != 12'h1FF
			|=> write_pointer == $past(write_pointer) + 12'h001;
	endproperty
	a_wr_step: assert property (p_wr_step)
		else $error("write counter did not step by one");

	property p_wr_wrap;
		wr_adv && write_pointer == 12'h1FF |=> write_pointer == 12'h000;
	endproperty
	a_wr_wrap: assert property (p_wr_wrap)
		else $error("write counter did not wrap after 511");

	property p_rd_wrap;
		rd_adv && read_pointer == 12'h1FF |=> read_pointer == 12'h000;
	endproperty
	a_rd_wrap: assert property (p_rd_wrap)
		else $error("read counter did not wrap after 511");

	property p_near_full;
		wfill != 10'h000 &&
			14'(wfill * 10'h009) >= {2'b00, near_full_threshold}
			|-> near_full_flag;
	endproperty
	a_near_full: assert property (p_near_full)
		else $error("near full missing at threshold");

	property p_near_empty;
		near_empty_flag |-> 14'(rfill * 10'h009) <=
			{2'b00, near_empty_threshold};
	endproperty
	a_near_empty: assert property (p_near_empty)
		else $error("near empty raised above threshold");

	property p_reset_state;
		$rose(nrst) |-> empty_flag && !full_flag && !near_full_flag &&
			write_pointer == 12'h000 && read_pointer == 12'h000;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("wrong state after reset");

	property p_reset_status;
		$rose(nrst) |=> status_ff == dcf_pkg::EV_RST;
	endproperty
	a_reset_status: assert property (p_reset_status)
		else $error("status event raised by reset itself");

	property p_sticky;
		events[dcf_pkg::EV_OVERFLOW] |=> status_ff[dcf_pkg::EV_OVERFLOW];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("overflow event lost");

endmodule : dcf_flag_fifo

/* File: bench/dcf_fabric_model.sv */
// Fabric user model: issues bursts of write or read requests.
// Assumes the FIFO takes one request per high cycle on clk.
module dcf_fabric_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Burst control
	input  wire logic        wr_start,
	input  wire logic        rd_start,
	input  wire logic [9:0]  burst_len,
	input  wire logic [9:0]  nf_words,
	input  wire logic [9:0]  ne_words,
	output logic             busy,
	// FIFO user side
	output logic             wr_req,
	output logic             rd_req,
	output logic [11:0]      nf_thr,
	output logic [11:0]      ne_thr
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [9:0] wr_left_ff;
	logic [9:0] rd_left_ff;

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wr_left_ff <= 10'h000;
			rd_left_ff <= 10'h000;
		end else begin
			if (wr_start) begin
				wr_left_ff <= burst_len;
			end else if (wr_req) begin
				wr_left_ff <= wr_left_ff - 10'h001;
			end
			if (rd_start) begin
				rd_left_ff <= burst_len;
			end else if (rd_req) begin
				rd_left_ff <= rd_left_ff - 10'h001;
			end
		end
	end

	// Requests move only after an edge, so each high cycle is one word
	assign wr_req = (wr_left_ff != 10'h000);
	assign rd_req = (rd_left_ff != 10'h000);
	assign busy   = wr_req | rd_req;
	// Thresholds in data bits, so odd port widths still line up
	assign nf_thr = 12'(nf_words * dcf_pkg::WORD_BITS);
	assign ne_thr = 12'(ne_words * dcf_pkg::WORD_BITS);

endmodule : dcf_fabric_model

/* File: bench/dcf_flag_fifo_bench.sv */
// Self-checking bench for the FIFO flag block.
// Assumes one 50 MHz clock and the fabric model on the user side.
module dcf_flag_fifo_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        wr_start = 1'b0;
	logic        rd_start = 1'b0;
	logic [9:0]  burst_len = 10'h000;
	logic        wr_halt = 1'b1;
	logic        rd_halt = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        busy, wr_req, rd_req, wr_acc, rd_acc, irq;
	logic        full, empty, nfull, nempty;
	logic [11:0] wptr, rptr, nf_thr, ne_thr;
	logic [31:0] reg_rdata, d;
	int          fail_count = 0;
	int          n_compared = 0;

	always #10 clk = ~clk;

	dcf_fabric_model FAB (.clk(clk), .nrst(nrst), .wr_start(wr_start),
		.rd_start(rd_start), .burst_len(burst_len), .nf_words(10'h190),
		.ne_words(10'h00A), .busy(busy), .wr_req(wr_req), .rd_req(rd_req),
		.nf_thr(nf_thr), .ne_thr(ne_thr));

	dcf_flag_fifo DUT (.clk(clk), .nrst(nrst), .wr_req(wr_req),
		.write_counter_halt(wr_halt), .write_accept(wr_acc),
		.write_pointer(wptr), .rd_req(rd_req), .read_counter_halt(rd_halt),
		.read_accept(rd_acc), .read_pointer(rptr),
		.near_full_threshold(nf_thr), .near_empty_threshold(ne_thr),
		.full_flag(full), .empty_flag(empty), .near_full_flag(nfull),
		.near_empty_flag(nempty), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq));

	////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// Burst of n requests; returns 1 ns after the edge that takes the last
	task automatic go(input logic w, input logic [9:0] n);
		int i;
		@(posedge clk);
		wr_start  <= w;
		rd_start  <= !w;
		burst_len <= n;
		@(posedge clk);
		wr_start <= 1'b0;
		rd_start <= 1'b0;
		for (i = 0; i < 1000; i++) begin
			tick(1);
			if (!busy) break;
		end
		if (i == 1000) begin
			fail_count++;
			conclude();
		end
	endtask : go

	task automatic rrd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rrd

	task automatic rwr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : rwr

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		#1;
		chk("rst", 32'h18, {wptr, rptr, empty, nempty, full, nfull, irq});
		rrd(dcf_pkg::REG_STATUS, d);
		chk("status", 32'h0, d);
		rrd(8'h20, d);
		chk("unmapped", 32'h0, d);
		go(1'b1, 10'h001);
		chk("empty c1", 32'h1, empty);
		tick(1);
		chk("empty c2", 32'h1, empty);
		tick(1);
		chk("empty c3", 32'h0, empty);
		chk("wptr", 32'h1, wptr);
		go(1'b1, 10'h18E);
		chk("nfull 399", 32'h0, nfull);
		go(1'b1, 10'h001);
		chk("nfull 400", 32'h1, nfull);
		rwr(dcf_pkg::REG_IRQ_EN, 32'h1 << dcf_pkg::EV_FULL);
		go(1'b1, 10'h070);
		chk("full", 32'h1, full);
		chk("wptr wrap", 32'h0, wptr);
		go(1'b1, 10'h003);
		chk("wptr held", 32'h0, wptr);
		rrd(dcf_pkg::REG_STATUS, d);
		chk("ovf", 32'h1, d[dcf_pkg::EV_OVERFLOW]);
		chk("irq", 32'h1, irq);
		rwr(dcf_pkg::REG_IRQ_CLR, 32'h1 << dcf_pkg::EV_FULL);
		tick(1);
		chk("irq clr", 32'h0, irq);
		go(1'b0, 10'h001);
		chk("full c1", 32'h1, full);
		tick(1);
		chk("full c2", 32'h1, full);
		tick(1);
		chk("full c3", 32'h0, full);
		go(1'b0, 10'h06F);
		tick(3);
		chk("nfull hold", 32'h1, nfull);
		go(1'b0, 10'h001);
		tick(3);
		chk("nfull drop", 32'h0, nfull);
		go(1'b0, 10'h184);
		tick(3);
		chk("nempty 11", 32'h0, nempty);
		go(1'b0, 10'h001);
		tick(3);
		chk("nempty 10", 32'h1, nempty);
		go(1'b0, 10'h00A);
		chk("empty", 32'h1, empty);
		chk("rptr wrap", 32'h0, rptr);
		go(1'b0, 10'h002);
		chk("rptr held", 32'h0, rptr);
		rrd(dcf_pkg::REG_STATUS, d);
		chk("udf", 32'h1, d[dcf_pkg::EV_UNDERFLOW]);
		@(posedge clk);
		rd_halt <= 1'b0;
		go(1'b0, 10'h003);
		chk("reread", 32'h3, rptr);
		conclude();
	end

endmodule : dcf_flag_fifo_bench
